// >>> rtl/sbcr_pkg.sv
/*
 * Constants for the serial bus control-register front end: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 32-bit Avalon-MM register bus clocked by the 40 MHz system clock.
 */
package sbcr_pkg;
	// Register byte offsets
	localparam logic [7:0] SBCR_OFS_ENABLE = 8'h00;
	localparam logic [7:0] SBCR_OFS_FORMAT = 8'h04;
	localparam logic [7:0] SBCR_OFS_MODE = 8'h10;
	// Enable register field
	localparam int SBCR_EN_BIT = 7;
	// Format register fields
	localparam int SBCR_BC_HI = 7;
	localparam int SBCR_BC_LO = 5;
	localparam int SBCR_ACK_BIT = 4;
	localparam int SBCR_ONE_BIT = 3;
	localparam int SBCR_SCK_HI = 2;
	localparam int SBCR_SCK_LO = 0;
	// Mode register fields
	localparam int SBCR_MST_BIT = 7;
	localparam int SBCR_MODE_HI = 3;
	localparam int SBCR_MODE_LO = 2;
	localparam int SBCR_SWR_HI = 1;
	localparam int SBCR_SWR_LO = 0;
	// Field codes
	localparam logic [1:0] SBCR_MODE_I2C = 2'h2;
	localparam logic [1:0] SBCR_SWR_FIRST = 2'h2;
	localparam logic [1:0] SBCR_SWR_SECOND = 2'h1;
	localparam logic [2:0] SBCR_BC_FULL = 3'h0;
	localparam logic [3:0] SBCR_LEN_FULL = 4'h8;
	localparam logic [2:0] SBCR_SCK_RSVD = 3'h7;
	localparam logic [2:0] SBCR_SCK_RST = 3'h0;
	localparam logic [2:0] SBCR_BC_RST = 3'h0;
	// Rate divider: period = 2^(code + base) + offset
	localparam int SBCR_SCK_NBASE = 5;
	localparam logic [11:0] SBCR_DIV_OFFSET = 12'h048;
	localparam logic [11:0] SBCR_DIV_ONE = 12'h001;
	// Software reset duration
	localparam int SBCR_CLK_MHZ = 40;
	localparam int SBCR_SWR_NS = 100;
	localparam int SBCR_SWR_CYC = (SBCR_SWR_NS * SBCR_CLK_MHZ + 999) / 1000;
	localparam logic [3:0] SBCR_SWR_CNT = 4'(SBCR_SWR_CYC);
	localparam logic [31:0] SBCR_ZERO = 32'h0000_0000;
endpackage

// >>> rtl/sbcr_ctrl.sv
/*
 * Control-register front end of a two-wire serial interface channel:
 * global enable, transfer format, acknowledge clocking, SCL rate divider
 * and the software-reset status monitor, behind an Avalon-MM slave.
 * Assumes a master that holds each request until waitrequest is seen low.
 */
// Functional notes
// - Enable bit 7 of the enable register turns the interface off at 0 and on at 1.
// - The other registers become accessible only after the enable bit was once set.
// - With the enable bit clear all interface clocking stops except the enable register.
// - Clearing the enable bit after use leaves every register's contents unchanged.
// - Code 000 gives 8 data bits, others their own count, plus one clock when ack is on.
// - In master mode the ack bit adds an acknowledge clock pulse after the data bits.
// - In slave mode the ack bit makes the acknowledge clock count as part of the transfer.
// - The SCL rate code sets a period of 2^n+72 system clocks, n = code+5, code 111 reserved.
// - Format bit 0 writes the lowest rate bit but reads back the reset status monitor.
// - The monitor reads 0 while a software reset runs and 1 otherwise.
// - After reset bit 0 reads 1 while the effective rate code is 000.
`timescale 1ns/100ps
module sbcr_ctrl
	import sbcr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic clk_run_o,
	output logic master_mode_o,
	output logic [3:0] data_len_o,
	output logic [3:0] clk_count_o,
	output logic ack_clk_gen_o,
	output logic ack_clk_count_o,
	output logic [11:0] scl_period_o,
	output logic scl_tick_o,
	output logic soft_rst_o
);
	logic en_q;
	logic ever_en_q;
	logic [2:0] bc_q;
	logic ack_q;
	logic [2:0] sck_q;
	logic mst_q;
	logic [1:0] mode_q;
	logic [1:0] swr_q;
	logic [3:0] swr_cnt_q;
	logic busy;
	logic [11:0] div_cnt_q;
	logic [11:0] period_d;
	logic [3:0] len_d;
	logic wr_take;
	logic rd_take;
	logic lane0;
	logic [31:0] rdata_d;
	logic [1:0] wr_mode;
	logic [1:0] wr_swr;

	// Bus handshake: a request is taken at the edge where waitrequest is low
	assign wr_take = avs_write_i && !avs_waitrequest_o;
	assign rd_take = avs_read_i && !avs_waitrequest_o;
	assign lane0 = avs_byteenable_i[0];
	assign busy = swr_cnt_q != 4'h0;
	assign wr_mode = avs_writedata_i[SBCR_MODE_HI:SBCR_MODE_LO];
	assign wr_swr = avs_writedata_i[SBCR_SWR_HI:SBCR_SWR_LO];

	// One wait cycle per request, then one ready cycle
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
			avs_waitrequest_o <= 1'b0;
		end else begin
			avs_waitrequest_o <= 1'b1;
		end
	end

	// Read data mux; gated registers read zero until first enable
	always_comb begin
		rdata_d = SBCR_ZERO;
		unique case (avs_address_i)
			SBCR_OFS_ENABLE: begin
				rdata_d[SBCR_EN_BIT] = en_q;
			end
			SBCR_OFS_FORMAT: begin
				if (ever_en_q) begin
					rdata_d[SBCR_BC_HI:SBCR_BC_LO] = bc_q;
					rdata_d[SBCR_ACK_BIT] = ack_q;
					rdata_d[SBCR_ONE_BIT] = 1'b1;
					rdata_d[SBCR_SCK_HI:SBCR_SCK_LO + 1] = sck_q[2:1];
					rdata_d[SBCR_SCK_LO] = !busy;
				end
			end
			default: begin
				rdata_d = SBCR_ZERO;
			end
		endcase
	end

	// Read data captured in the wait cycle, stands at the taking edge
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata_o <= SBCR_ZERO;
		end else if (avs_read_i && avs_waitrequest_o) begin
			avs_readdata_o <= rdata_d;
		end
	end

	// Enable register and first-enable latch; its clock is never gated
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
			ever_en_q <= 1'b0;
		end else if (wr_take && lane0 && avs_address_i == SBCR_OFS_ENABLE) begin
			en_q <= avs_writedata_i[SBCR_EN_BIT];
			if (avs_writedata_i[SBCR_EN_BIT]) begin
				ever_en_q <= 1'b1;
			end
		end
	end

	// Format register; frozen while disabled, cleared by software reset
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			bc_q <= SBCR_BC_RST;
			ack_q <= 1'b0;
			sck_q <= SBCR_SCK_RST;
		end else if (en_q) begin
			if (swr_cnt_q == SBCR_SWR_CNT) begin
				bc_q <= SBCR_BC_RST;
				ack_q <= 1'b0;
				sck_q <= SBCR_SCK_RST;
			end else if (wr_take && lane0 && avs_address_i == SBCR_OFS_FORMAT) begin
				bc_q <= avs_writedata_i[SBCR_BC_HI:SBCR_BC_LO];
				ack_q <= avs_writedata_i[SBCR_ACK_BIT];
				sck_q <= avs_writedata_i[SBCR_SCK_HI:SBCR_SCK_LO];
			end
		end
	end

	// Mode register (write only) with the reset trigger sequence
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			mst_q <= 1'b0;
			mode_q <= 2'h0;
			swr_q <= 2'h0;
		end else if (en_q && wr_take && lane0 && avs_address_i == SBCR_OFS_MODE) begin
			mst_q <= avs_writedata_i[SBCR_MST_BIT];
			mode_q <= wr_mode;
			swr_q <= wr_swr;
		end
	end

	// Software reset timer, started by 10 then 01 written in I2C mode
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			swr_cnt_q <= 4'h0;
		end else if (en_q) begin
			if (wr_take && lane0 && avs_address_i == SBCR_OFS_MODE && wr_mode == SBCR_MODE_I2C
				&& mode_q == SBCR_MODE_I2C && swr_q == SBCR_SWR_FIRST
				&& wr_swr == SBCR_SWR_SECOND) begin
				swr_cnt_q <= SBCR_SWR_CNT;
			end else if (busy) begin
				swr_cnt_q <= swr_cnt_q - 4'h1;
			end
		end
	end

	// Transfer length derived from the format bit count field; the clock count adds ack in the output register
	always_comb begin
		len_d = (bc_q == SBCR_BC_FULL) ? SBCR_LEN_FULL : {1'b0, bc_q};
	end

	// Rate divider period; reserved code falls back to the slowest defined rate
	always_comb begin
		if (sck_q == SBCR_SCK_RSVD) begin
			period_d = (SBCR_DIV_ONE << (SBCR_SCK_NBASE + 6)) + SBCR_DIV_OFFSET;
		end else begin
			period_d = (SBCR_DIV_ONE << (SBCR_SCK_NBASE + int'(sck_q))) + SBCR_DIV_OFFSET;
		end
	end

	// Registered format outputs toward the bus engine
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			clk_run_o <= 1'b0;
			master_mode_o <= 1'b0;
			data_len_o <= SBCR_LEN_FULL;
			clk_count_o <= SBCR_LEN_FULL;
			ack_clk_gen_o <= 1'b0;
			ack_clk_count_o <= 1'b0;
			scl_period_o <= SBCR_DIV_OFFSET;
			soft_rst_o <= 1'b0;
		end else begin
			clk_run_o <= en_q;
			master_mode_o <= mst_q;
			data_len_o <= len_d;
			clk_count_o <= len_d + {3'h0, ack_q};
			ack_clk_gen_o <= mst_q && ack_q;
			ack_clk_count_o <= !mst_q && ack_q;
			scl_period_o <= period_d;
			soft_rst_o <= busy;
		end
	end

	// SCL rate divider, running only when enabled in master mode
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_q <= 12'h000;
			scl_tick_o <= 1'b0;
		end else if (en_q && mst_q) begin
			if (div_cnt_q + SBCR_DIV_ONE >= period_d) begin
				div_cnt_q <= 12'h000;
				scl_tick_o <= 1'b1;
			end else begin
				div_cnt_q <= div_cnt_q + SBCR_DIV_ONE;
				scl_tick_o <= 1'b0;
			end
		end else begin
			scl_tick_o <= 1'b0;
		end
	end

	// Checks
	chk_enable_on: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(wr_take && lane0 && avs_address_i == SBCR_OFS_ENABLE && avs_writedata_i[SBCR_EN_BIT])
		|=> ##1 clk_run_o) else $error("enable write did not start interface");
	chk_gated_read_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(rd_take && avs_address_i == SBCR_OFS_FORMAT && !ever_en_q)
		|-> avs_readdata_o == SBCR_ZERO) else $error("gated register read nonzero");
	chk_gated_write_drop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!ever_en_q) |=> $stable({bc_q, ack_q, sck_q})) else $error("write before enable");
	chk_disabled_freeze: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(ever_en_q && !en_q) |=> $stable({bc_q, ack_q, sck_q, mst_q, swr_cnt_q}))
		else $error("register changed while disabled");
	chk_divider_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!en_q) |=> $stable(div_cnt_q) && !scl_tick_o) else $error("divider ran while disabled");
	chk_clock_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		1'b1 |=> clk_count_o == ($past(bc_q) == 3'h0 ? 4'h8 : {1'b0, $past(bc_q)})
		+ {3'h0, $past(ack_q)}) else $error("clock count wrong");
	chk_ack_master: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(mst_q && ack_q) |=> ack_clk_gen_o && !ack_clk_count_o) else $error("ack clock not made");
	chk_ack_slave: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(!mst_q) |=> ack_clk_count_o == $past(ack_q) && !ack_clk_gen_o)
		else $error("slave ack counting wrong");
	chk_rate_period: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(sck_q != 3'h7) |=> scl_period_o == (12'h001 << (5 + int'($past(sck_q)))) + 12'h048)
		else $error("scl period wrong");
	chk_monitor_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(rd_take && avs_address_i == SBCR_OFS_FORMAT && ever_en_q)
		|-> avs_readdata_o[0] == !$past(busy)) else $error("monitor bit wrong");
	chk_reset_length: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$rose(busy) && en_q |-> busy [*4] ##1 !busy) else $error("reset length wrong");
endmodule

// >>> sim/sbcr_scl_peer.sv
/*
 * Far-side model: a bus device that watches the SCL tick and measures
 * how many system clocks pass between two ticks.
 * Assumes it shares the system clock and reset of the block.
 */
`timescale 1ns/100ps
module sbcr_scl_peer (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic scl_tick_i,
	output logic [11:0] gap_o
);
	logic [11:0] cnt_q;
	// Cycles since the last tick become the seen period
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 12'h001;
			gap_o <= 12'h000;
		end else if (scl_tick_i) begin
			cnt_q <= 12'h001;
			gap_o <= cnt_q;
		end else begin
			cnt_q <= cnt_q + 12'h001;
		end
	end
endmodule

// >>> sim/sbcr_ctrl_tb_top.sv
/*
 * Self-checking bench for the control-register front end.
 * Assumes the package, the block and the far-side model compile first.
 */
`timescale 1ns/100ps
module sbcr_ctrl_tb_top;
	import sbcr_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr_q = 8'h00;
	logic rd_q = 1'b0;
	logic wr_q = 1'b0;
	logic [3:0] be_q = 4'h1;
	logic [31:0] wd_q = 32'h0000_0000;
	logic [31:0] rdata, rd_v;
	logic wreq, run, mst, agen, acnt, tick, srst;
	logic [3:0] dlen, ccnt;
	logic [11:0] per, gap;
	logic [7:0] f;
	logic [2:0] s;
	int bad_count = 0;
	int n_tests = 0;
	int seed = 32'h8c50;
	int i, k, n, r;
	// Clock of 25 ns
	always #12.5 clk_sys_i = ~clk_sys_i;
	sbcr_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(adr_q),
		.avs_read_i(rd_q), .avs_write_i(wr_q), .avs_byteenable_i(be_q),
		.avs_writedata_i(wd_q), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.clk_run_o(run), .master_mode_o(mst), .data_len_o(dlen), .clk_count_o(ccnt),
		.ack_clk_gen_o(agen), .ack_clk_count_o(acnt), .scl_period_o(per),
		.scl_tick_o(tick), .soft_rst_o(srst));
	sbcr_scl_peer peer_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_tick_i(tick),
		.gap_o(gap));
	// Verdict and end of run
	task final_report;
		$display("tests %0d errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		adr_q <= a;
		wd_q <= d;
		rd_q <= !w;
		wr_q <= w;
		for (i = 0; i < 20 && wreq !== 1'b0; i++) begin
			@(posedge clk_sys_i);
		end
		if (i == 0 || wreq !== 1'b0) begin
			@(posedge clk_sys_i);
		end
		rd_v = rdata;
		rd_q <= 1'b0;
		wr_q <= 1'b0;
		if (i == 20) begin
			bad_count++;
			final_report;
		end
	endtask
	task settle;
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask
	function automatic logic [3:0] len_f(input logic [2:0] b);
		return (b == 3'h0) ? 4'h8 : {1'b0, b};
	endfunction
	function automatic logic [11:0] per_f(input logic [2:0] c);
		return (12'h001 << ((c == 3'h7) ? 11 : c + 5)) + 12'h048;
	endfunction
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		// Gated registers before the first enable
		bus(1'b1, SBCR_OFS_FORMAT, 32'h0000_00f0);
		bus(1'b0, SBCR_OFS_FORMAT, 32'h0000_0000);
		chk("fmt_pre", 32'h0000_0000, rd_v);
		bus(1'b0, SBCR_OFS_ENABLE, 32'h0000_0000);
		chk("en_rst", 32'h0000_0000, rd_v);
		be_q <= 4'he;
		bus(1'b1, SBCR_OFS_ENABLE, 32'h0000_0080);
		settle;
		chk("run_be", 32'h0000_0000, 32'(run));
		be_q <= 4'h1;
		bus(1'b1, SBCR_OFS_ENABLE, 32'h0000_00ff);
		settle;
		chk("run", 32'h0000_0001, 32'(run));
		bus(1'b0, SBCR_OFS_ENABLE, 32'h0000_0000);
		chk("en_rd", 32'h0000_0080, rd_v);
		bus(1'b0, SBCR_OFS_FORMAT, 32'h0000_0000);
		chk("fmt_rst", 32'h0000_0009, rd_v);
		chk("per_rst", 32'(per_f(3'h0)), 32'(per));
		// Every length and rate code, both modes, random ack and bit 3
		for (k = 0; k < 16; k++) begin
			r = $random(seed);
			f = {k[2:0], r[0], r[1], k[3:1]};
			bus(1'b1, SBCR_OFS_MODE, {24'h0, k[0], 3'h0, SBCR_MODE_I2C, 2'h0});
			bus(1'b1, SBCR_OFS_FORMAT, {24'h0, f});
			settle;
			chk("len", 32'(len_f(f[7:5])), 32'(dlen));
			chk("cnt", 32'(len_f(f[7:5]) + 4'(f[4])), 32'(ccnt));
			chk("agen", 32'(k[0] & f[4]), 32'(agen));
			chk("acnt", 32'(!k[0] & f[4]), 32'(acnt));
			chk("mst", 32'(k[0]), 32'(mst));
			chk("per", 32'(per_f(f[2:0])), 32'(per));
			bus(1'b0, SBCR_OFS_FORMAT, 32'h0000_0000);
			chk("fmt", {24'h0, f[7:4], 1'b1, f[2:1], 1'b1}, rd_v);
		end
		// Rate seen by the far side; master mode is still selected
		for (s = 3'h0; s < 3'h2; s++) begin
			bus(1'b1, SBCR_OFS_FORMAT, {29'h0, s});
			n = 0;
			for (k = 0; k < 1000 && n < 3; k++) begin
				@(posedge clk_sys_i);
				if (tick === 1'b1)
					n++;
			end
			#1;
			chk("ticks", 32'h0000_0003, 32'(n));
			chk("gap", 32'(per_f(s)), 32'(gap));
		end
		// Software reset sequence, then the cleared format
		bus(1'b1, SBCR_OFS_FORMAT, 32'h0000_00f6);
		bus(1'b1, SBCR_OFS_MODE, 32'h0000_008a);
		bus(1'b1, SBCR_OFS_MODE, 32'h0000_0089);
		// Monitor reads 0 and the format is already cleared while the reset runs
		bus(1'b0, SBCR_OFS_FORMAT, 32'h0000_0000);
		chk("mon_busy", 32'h0000_0008, rd_v);
		for (k = 0; k < 8 && srst !== 1'b1; k++) @(posedge clk_sys_i);
		chk("srst", 32'h0000_0001, 32'(srst));
		for (k = 0; k < 20 && srst !== 1'b0; k++) @(posedge clk_sys_i);
		chk("srst_end", 32'h0000_0000, 32'(srst));
		bus(1'b0, SBCR_OFS_FORMAT, 32'h0000_0000);
		chk("fmt_swr", 32'h0000_0009, rd_v);
		// Disable keeps contents and blocks writes
		bus(1'b1, SBCR_OFS_FORMAT, 32'h0000_0040);
		bus(1'b1, SBCR_OFS_ENABLE, 32'h0000_0000);
		settle;
		chk("run_off", 32'h0000_0000, 32'(run));
		bus(1'b1, SBCR_OFS_FORMAT, 32'h0000_00e0);
		bus(1'b0, SBCR_OFS_FORMAT, 32'h0000_0000);
		chk("fmt_keep", 32'h0000_0049, rd_v);
		bus(1'b0, 8'h20, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, rd_v);
		final_report;
	end
endmodule
